/* inc/tg_pkg.sv */
// shared constants and types for the tile bus glue
package tg_pkg;

    // ----------------------------------------
    // bus encodings
    // ----------------------------------------
    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam logic HRESP_OKAY = 1'h0;
    localparam logic HRESP_ERROR = 1'h1;

    // ----------------------------------------
    // address map of the two master-side buses
    // ----------------------------------------
    localparam logic [31:0] M1_TILE_BASE = 32'hC000_0000;
    localparam logic [31:0] M1_TILE_LAST = 32'hCFFF_FFFF;
    localparam logic [31:0] M2_LOW_BASE = 32'h0000_0000;
    localparam logic [31:0] M2_LOW_LAST = 32'h03FF_FFFF;
    localparam logic [31:0] M2_ALIAS_BASE = 32'h1400_0000;
    localparam logic [31:0] M2_ALIAS_LAST = 32'h1FFF_FFFF;

    // ----------------------------------------
    // configuration register map
    // ----------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_ERRCNT = 8'h08;
    localparam int CTRL_HAS_MASTERS = 0;
    localparam int CTRL_SSRAM_ON_M2 = 1;
    localparam int CTRL_S_SELECT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h6;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] trans;
        logic [31:0] addr;
        logic write;
        logic [2:0] size;
        logic [31:0] wdata;
    } tg_ahb_req_t;

    typedef struct packed {
        logic busReq;
        logic lock;
        tg_ahb_req_t bus;
    } tg_tm_req_t;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_OK = 2'b01,
        PH_ERR1 = 2'b10,
        PH_ERR2 = 2'b11
    } tg_phase_t;

endpackage : tg_pkg

/* rtl/tg_ahb_port.sv */
// response port of one master-side bus: memory slave plus default slave
`timescale 1ns/100ps
module tg_ahb_port #(
    parameter int DEPTH_LOG2 = 10
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // bus side
    input tg_pkg::tg_ahb_req_t busReq,
    input wire logic busHready,
    input wire logic hitMem,
    input wire logic hitAny,
    // response side
    output logic readyOut,
    output logic respOut,
    output logic [31:0] rdataOut,
    output logic drvEn,
    output logic errPulse
);
    import tg_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [31:0] mem [0:(1 << DEPTH_LOG2) - 1];
    tg_phase_t phase_reg;
    tg_phase_t phase_next;
    logic wrPend_reg;
    logic [DEPTH_LOG2-1:0] wrIdx_reg;

    wire logic take = busHready && busReq.trans[1];
    // low bits only: the boot alias lands on the same words
    wire logic [DEPTH_LOG2-1:0] idx = busReq.addr[DEPTH_LOG2+1:2];
    wire logic fwd = wrPend_reg && (wrIdx_reg == idx);

    // ----------------------------------------
    // data phase sequencing
    // ----------------------------------------
    always_comb
    begin
        phase_next = phase_reg;
        case (phase_reg)
            PH_ERR1: phase_next = PH_ERR2;
            default:
            begin
                if (busHready)
                begin
                    if (!take || !hitAny)
                        phase_next = PH_IDLE;
                    else if (hitMem)
                        phase_next = PH_OK;
                    else
                        phase_next = PH_ERR1;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            phase_reg <= PH_IDLE;
            readyOut <= 1'b1;
            respOut <= HRESP_OKAY;
            drvEn <= 1'b0;
            errPulse <= 1'b0;
        end
        else
        begin
            phase_reg <= phase_next;
            readyOut <= (phase_next != PH_ERR1);
            respOut <= phase_next[1] ? HRESP_ERROR : HRESP_OKAY;
            drvEn <= (phase_next != PH_IDLE);
            errPulse <= (phase_next == PH_ERR1);
        end
    end

    // ----------------------------------------
    // storage
    // ----------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            wrPend_reg <= 1'b0;
        else if (take)
            wrPend_reg <= hitAny && hitMem && busReq.write;
        else if (busHready)
            wrPend_reg <= 1'b0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (take)
            wrIdx_reg <= idx;
    end

    always_ff @(posedge ref_clk)
    begin
        if (wrPend_reg && busHready)
            mem[wrIdx_reg] <= busReq.wdata;
    end

    // forwarding covers a read right behind a write to the same word
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            rdataOut <= 32'h0000_0000;
        else if (take && hitAny && hitMem)
            rdataOut <= fwd ? busReq.wdata : mem[idx];
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_err_two_cycle;
        @(posedge ref_clk) disable iff (sys_rst)
        (take && hitAny && !hitMem) |=> (!readyOut && respOut) ##1 (readyOut && respOut);
    endproperty
    a_err_two_cycle: assert property (p_err_two_cycle) else $error("bad error reply");

    property p_no_drive_miss;
        @(posedge ref_clk) disable iff (sys_rst)
        (take && !hitAny && phase_reg != PH_ERR1) |=> !drvEn;
    endproperty
    a_no_drive_miss: assert property (p_no_drive_miss) else $error("drives on a miss");

    property p_drive_hit;
        @(posedge ref_clk) disable iff (sys_rst)
        (take && hitAny && phase_reg != PH_ERR1) |=> drvEn && (readyOut == $past(hitMem));
    endproperty
    a_drive_hit: assert property (p_drive_hit) else $error("no drive on a hit");

endmodule : tg_ahb_port

/* rtl/tg_bus_glue.sv */
// bus glue of an expansion logic tile: default slaves, ties and shared-bus arbiter
// ----------------------------------------
// Summary of operation
// - tile drives every bridge control signal itself
// - default slave ends misses with ERROR
// - first bus: answer every address
// - second bus: answer only low and alias ranges
// - first bus real slave sits at 0xC0000000
// - first bus drivers enabled only on own access
// - second bus drivers enabled only on tile access
// - both master-side grants held high
// - slave-side bridge select follows CTRL bit 2 (high after reset)
// - responses from tile slave or default slave
// - arbiter shares slave-side bus with PCI master
// - bottom tile multiplexes tile masters onto bus
// - no masters: slave-side outputs left undriven
// - no masters: PCI grant held high
// - no masters: locked indication held low
// - SSRAM on second bus at both ranges
// - alias range reaches the same storage
// ----------------------------------------
//
// Local design decisions: the AHB-Lite register port and the register addresses.
`timescale 1ns/100ps
module tg_bus_glue #(
    parameter int N_MASTERS = 2,
    parameter int M1_DEPTH_LOG2 = 10,
    parameter int M2_DEPTH_LOG2 = 12,
    parameter bit M1_OWNS_ALL = 1'b1
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // configuration bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // presence pin
    input wire logic tilePresentDetect_n,
    // first master-side bus
    input tg_pkg::tg_ahb_req_t m1Bus,
    input wire logic m1Hready,
    output logic m1BridgeGrant,
    output logic m1SlaveReady,
    output logic m1SlaveResponse,
    output logic [31:0] m1SlaveRdata,
    output logic m1SlaveOe,
    // second master-side bus
    input tg_pkg::tg_ahb_req_t m2Bus,
    input wire logic m2Hready,
    output logic m2BridgeGrant,
    output logic m2SlaveReady,
    output logic m2SlaveResponse,
    output logic [31:0] m2SlaveRdata,
    output logic m2SlaveOe,
    // slave-side bus
    input tg_pkg::tg_tm_req_t [N_MASTERS-1:0] tileMaster,
    input wire logic sBusHready,
    input wire logic pciMasterRequest,
    input wire logic pciMasterLockRequest,
    output logic [N_MASTERS-1:0] tileMasterGrant,
    output tg_pkg::tg_ahb_req_t sBusOut,
    output logic sBusOe,
    output logic sBusLockedTransfer,
    output logic pciMasterGrant,
    output logic sBridgeSelect
);
    import tg_pkg::*;

    localparam int OW = $clog2(N_MASTERS + 1);
    localparam logic [OW-1:0] OWNER_PCI = OW'(N_MASTERS);

    function automatic logic inRange(input logic [31:0] a, input logic [31:0] lo,
                                     input logic [31:0] hi);
        inRange = (a >= lo) && (a <= hi);
    endfunction : inRange

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [2:0] pinMeta_reg;
    logic [2:0] pinSync_reg;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            pinMeta_reg <= 3'h1;
            pinSync_reg <= 3'h1;
        end
        else
        begin
            pinMeta_reg <= {pciMasterLockRequest, pciMasterRequest, tilePresentDetect_n};
            pinSync_reg <= pinMeta_reg;
        end
    end

    wire logic tilePresent = !pinSync_reg[0];
    wire logic pciReq = pinSync_reg[1];
    wire logic pciLock = pinSync_reg[2];

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    logic [2:0] ctrl_reg;
    logic [15:0] errCnt_reg;
    logic cfgWrPend_reg;
    logic [7:0] cfgAddr_reg;
    logic [OW-1:0] owner_reg;

    wire logic cfgTake = hsel && hready && htrans[1];
    wire logic cfgHasMasters = ctrl_reg[CTRL_HAS_MASTERS];
    // expansion boot: processor fetches from the alias-free low range at once
    wire logic cfgSsramOnM2 = ctrl_reg[CTRL_SSRAM_ON_M2];
    wire logic cfgSelect = ctrl_reg[CTRL_S_SELECT];
    wire logic m1Err;
    wire logic m2Err;

    logic [31:0] cfgReadValue;
    always_comb
    begin
        if (haddr[7:0] == REG_CTRL)
            cfgReadValue = {29'h0000_0000, ctrl_reg};
        else if (haddr[7:0] == REG_STATUS)
            cfgReadValue = {{(30 - OW){1'b0}}, owner_reg, pciMasterGrant, tilePresent};
        else if (haddr[7:0] == REG_ERRCNT)
            cfgReadValue = {16'h0000, errCnt_reg};
        else
            cfgReadValue = 32'h0000_0000;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            cfgWrPend_reg <= 1'b0;
            cfgAddr_reg <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
        end
        else
        begin
            cfgWrPend_reg <= cfgTake && hwrite;
            if (cfgTake)
                cfgAddr_reg <= haddr[7:0];
            if (cfgTake && !hwrite)
                hrdata <= cfgReadValue;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            ctrl_reg <= CTRL_RESET;
        else if (cfgWrPend_reg && cfgAddr_reg == REG_CTRL)
            ctrl_reg <= hwdata[2:0];
    end

    // an event in the clearing cycle is counted after the clear
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            errCnt_reg <= 16'h0000;
        else if (cfgWrPend_reg && cfgAddr_reg == REG_ERRCNT)
            errCnt_reg <= 16'(m1Err) + 16'(m2Err);
        else
            errCnt_reg <= errCnt_reg + 16'(m1Err) + 16'(m2Err);
    end

    // ----------------------------------------
    // master-side response ports
    // ----------------------------------------
    wire logic m1HitMem = inRange(m1Bus.addr, M1_TILE_BASE, M1_TILE_LAST);
    wire logic m1HitAny = M1_OWNS_ALL || m1HitMem;
    wire logic m2InMap = inRange(m2Bus.addr, M2_LOW_BASE, M2_LOW_LAST)
                      || inRange(m2Bus.addr, M2_ALIAS_BASE, M2_ALIAS_LAST);
    wire logic m2HitMem = m2InMap && cfgSsramOnM2;

    tg_ahb_port #(
        .DEPTH_LOG2(M1_DEPTH_LOG2)
    ) u_m1Port (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .busReq(m1Bus),
        .busHready(m1Hready),
        .hitMem(m1HitMem),
        .hitAny(m1HitAny),
        .readyOut(m1SlaveReady),
        .respOut(m1SlaveResponse),
        .rdataOut(m1SlaveRdata),
        .drvEn(m1SlaveOe),
        .errPulse(m1Err)
    );

    tg_ahb_port #(
        .DEPTH_LOG2(M2_DEPTH_LOG2)
    ) u_m2Port (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .busReq(m2Bus),
        .busHready(m2Hready),
        .hitMem(m2HitMem),
        .hitAny(m2InMap),
        .readyOut(m2SlaveReady),
        .respOut(m2SlaveResponse),
        .rdataOut(m2SlaveRdata),
        .drvEn(m2SlaveOe),
        .errPulse(m2Err)
    );

    // ----------------------------------------
    // fixed grant levels and configured bridge select
    // ----------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            m1BridgeGrant <= 1'b1;
            m2BridgeGrant <= 1'b1;
            sBridgeSelect <= 1'b1;
        end
        else
        begin
            m1BridgeGrant <= 1'b1;
            m2BridgeGrant <= 1'b1;
            sBridgeSelect <= cfgSelect;
        end
    end

    // ----------------------------------------
    // slave-side arbiter, lowest tile index first, PCI parks the bus
    // ----------------------------------------
    logic [OW-1:0] pick;
    always_comb
    begin
        pick = OWNER_PCI;
        for (int i = N_MASTERS - 1; i >= 0; i--)
        begin
            if (tileMaster[i].busReq)
                pick = OW'(i);
        end
    end

    wire logic ownerIsPci = (owner_reg == OWNER_PCI);
    wire logic ownerLock = ownerIsPci ? pciLock : tileMaster[owner_reg].lock;
    // a locked sequence keeps the bus until its lock request drops
    wire logic [OW-1:0] nextOwner = !cfgHasMasters ? OWNER_PCI
                                  : (!sBusHready || ownerLock) ? owner_reg
                                  : (pciReq && pick == OWNER_PCI) ? OWNER_PCI : pick;
    logic [OW-1:0] dataOwner_reg;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            owner_reg <= OWNER_PCI;
            dataOwner_reg <= OWNER_PCI;
            pciMasterGrant <= 1'b1;
            tileMasterGrant <= '0;
            sBusLockedTransfer <= 1'b0;
            sBusOe <= 1'b0;
        end
        else
        begin
            owner_reg <= nextOwner;
            if (sBusHready)
                dataOwner_reg <= owner_reg;
            pciMasterGrant <= (nextOwner == OWNER_PCI);
            for (int i = 0; i < N_MASTERS; i++)
                tileMasterGrant[i] <= (nextOwner == OW'(i));
            sBusLockedTransfer <= cfgHasMasters && ownerLock;
            sBusOe <= cfgHasMasters && !ownerIsPci;
        end
    end

    // address phase relayed from the owner, data from the previous owner
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            sBusOut <= '0;
        else
        begin
            if (ownerIsPci)
            begin
                sBusOut.trans <= HTRANS_IDLE;
                sBusOut.addr <= 32'h0000_0000;
                sBusOut.write <= 1'b0;
                sBusOut.size <= 3'h0;
            end
            else
            begin
                sBusOut.trans <= tileMaster[owner_reg].bus.trans;
                sBusOut.addr <= tileMaster[owner_reg].bus.addr;
                sBusOut.write <= tileMaster[owner_reg].bus.write;
                sBusOut.size <= tileMaster[owner_reg].bus.size;
            end
            if (dataOwner_reg != OWNER_PCI)
                sBusOut.wdata <= tileMaster[dataOwner_reg].bus.wdata;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_pci_grant;
        @(posedge ref_clk) disable iff (sys_rst)
        !cfgHasMasters |=> pciMasterGrant && (tileMasterGrant == '0);
    endproperty
    a_pci_grant: assert property (p_pci_grant) else $error("PCI grant low");

    property p_lock_low;
        @(posedge ref_clk) disable iff (sys_rst)
        !cfgHasMasters |=> !sBusLockedTransfer;
    endproperty
    a_lock_low: assert property (p_lock_low) else $error("lock not low");

    property p_s_undriven;
        @(posedge ref_clk) disable iff (sys_rst)
        !cfgHasMasters |=> !sBusOe;
    endproperty
    a_s_undriven: assert property (p_s_undriven) else $error("slave bus driven");

    property p_grants_high;
        @(posedge ref_clk) disable iff (sys_rst)
        1'b1 |-> m1BridgeGrant && m2BridgeGrant;
    endproperty
    a_grants_high: assert property (p_grants_high) else $error("bridge grant low");

    property p_select;
        @(posedge ref_clk) disable iff (sys_rst)
        cfgSelect |=> sBridgeSelect;
    endproperty
    a_select: assert property (p_select) else $error("select low");

    property p_one_grant;
        @(posedge ref_clk) disable iff (sys_rst)
        ##1 $onehot({tileMasterGrant, pciMasterGrant});
    endproperty
    a_one_grant: assert property (p_one_grant) else $error("grant not one-hot");

    property p_m1_all;
        @(posedge ref_clk) disable iff (sys_rst)
        (M1_OWNS_ALL && m1Hready && m1Bus.trans[1]) |=> m1SlaveOe;
    endproperty
    a_m1_all: assert property (p_m1_all) else $error("first bus miss unanswered");

    property p_m2_out;
        @(posedge ref_clk) disable iff (sys_rst)
        (m2Hready && m2Bus.trans[1] && !m2InMap && !m2SlaveOe) |=> !m2SlaveOe;
    endproperty
    a_m2_out: assert property (p_m2_out) else $error("second bus driven off map");

endmodule : tg_bus_glue

/* tb/tg_bus_glue_tb.sv */
// self-checking bench of the tile bus glue
`timescale 1ns/100ps
module tg_bus_glue_tb;
    import tg_pkg::*;
    localparam int TIMEOUT_CYCLES = 5000;
    logic ref_clk;
    logic sys_rst;
    logic hsel, hwrite, hready, hreadyout, hresp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, m1SlaveRdata, m2SlaveRdata;
    logic tilePresentDetect_n, sBusHready, sBusOe, sBusLockedTransfer, sBridgeSelect;
    logic m1BridgeGrant, m1SlaveReady, m1SlaveResponse, m1SlaveOe;
    logic m2BridgeGrant, m2SlaveReady, m2SlaveResponse, m2SlaveOe;
    logic pciMasterGrant, pciMasterRequest, pciMasterLockRequest, pciStart, pciOwned;
    logic [1:0] tileMasterGrant;
    tg_tm_req_t [1:0] tileMaster;
    tg_ahb_req_t sBusOut;
    tg_ahb_req_t [2:0] busArr;
    logic [2:0] rdyArr, respArr, oeArr;
    logic [2:0][31:0] rdArr;
    logic [31:0] rd;
    logic rs, oe;
    int w, errCount, nChecks, cycles;
    int unsigned errAddr [3] = '{32'h0000_1000, 32'hBFFF_FFFC, 32'hD000_0000};

    // ----------------------------------------
    // bus resolution: the baseboard answers wherever the tile is quiet
    // ----------------------------------------
    assign hsel = busArr[0].trans[1];
    assign haddr = busArr[0].addr;
    assign htrans = busArr[0].trans;
    assign hwrite = busArr[0].write;
    assign hsize = busArr[0].size;
    assign hwdata = busArr[0].wdata;
    assign hready = hreadyout;
    assign rdyArr = {m2SlaveOe ? m2SlaveReady : 1'b1, m1SlaveOe ? m1SlaveReady : 1'b1, hreadyout};
    assign respArr = {m2SlaveResponse, m1SlaveResponse, hresp};
    assign oeArr = {m2SlaveOe, m1SlaveOe, 1'b1};
    assign rdArr = {m2SlaveRdata, m1SlaveRdata, hrdata};

    tg_bus_glue dut (.ref_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hrdata, .hreadyout, .hresp, .tilePresentDetect_n, .m1Bus(busArr[1]),
        .m1Hready(rdyArr[1]), .m1BridgeGrant, .m1SlaveReady, .m1SlaveResponse, .m1SlaveRdata,
        .m1SlaveOe, .m2Bus(busArr[2]), .m2Hready(rdyArr[2]), .m2BridgeGrant, .m2SlaveReady,
        .m2SlaveResponse, .m2SlaveRdata, .m2SlaveOe, .tileMaster, .sBusHready,
        .pciMasterRequest, .pciMasterLockRequest, .tileMasterGrant, .sBusOut, .sBusOe,
        .sBusLockedTransfer, .pciMasterGrant, .sBridgeSelect);

    tg_pci_master_model pci (.ref_clk, .sys_rst, .start(pciStart), .holdOff(4'h3),
        .pciMasterGrant, .pciMasterRequest, .pciMasterLockRequest, .owned(pciOwned));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic end_sim();
        $display("checks %0d mismatches %0d", nChecks, errCount);
        if (errCount == 0 && nChecks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp)
        begin
            errCount++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // bus 0 config, 1 first master-side, 2 second master-side
    task automatic xfer(input int b, input logic [31:0] a, input logic wr,
        input logic [31:0] wd);
        w = 0;
        busArr[b] <= '{trans: 2'h2, addr: a, write: wr, size: 3'h2, wdata: 32'h0};
        do @(posedge ref_clk); while (rdyArr[b] !== 1'b1);
        busArr[b] <= '{trans: HTRANS_IDLE, addr: a, write: wr, size: 3'h2, wdata: wd};
        @(posedge ref_clk);
        while (rdyArr[b] !== 1'b1)
        begin
            w++;
            @(posedge ref_clk);
        end
        rd = rdArr[b];
        rs = respArr[b];
        oe = oeArr[b];
    endtask : xfer

    // ----------------------------------------
    // clock and watchdog
    // ----------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == TIMEOUT_CYCLES)
        begin
            errCount++;
            end_sim();
        end
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        sys_rst = 1'b1;
        busArr = '0;
        tileMaster = '0;
        sBusHready = 1'b1;
        tilePresentDetect_n = 1'b0;
        pciStart = 1'b0;
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        // a tile master asks while the tile is configured masterless
        tileMaster[0] <= '{busReq: 1'b1, lock: 1'b0,
            bus: '{trans: 2'h2, addr: 32'hABCD_0000, write: 1'b0, size: 3'h2, wdata: 32'h0}};
        xfer(2, 32'h0, 1'b0, 32'h0);
        chk(32'({oe, rs, w[0]}), 32'h4);
        xfer(0, 32'(REG_CTRL), 1'b0, 32'h0);
        chk(rd, 32'(CTRL_RESET));
        xfer(0, 32'(REG_STATUS), 1'b0, 32'h0);
        chk(32'(rd[1:0]), 32'h3);
        chk(32'({m1BridgeGrant, m2BridgeGrant, sBridgeSelect}), 32'h7);
        chk(32'({pciMasterGrant, tileMasterGrant, sBusLockedTransfer, sBusOe}), 32'h10);
        $display("test ties done");

        xfer(1, 32'hC000_0020, 1'b1, 32'h5A5A_1234);
        chk(32'({oe, rs, w[0]}), 32'h4);
        xfer(1, 32'hC000_0020, 1'b0, 32'h0);
        chk(rd, 32'h5A5A_1234);
        foreach (errAddr[i])
        begin
            xfer(1, errAddr[i], 1'b0, 32'h0);
            chk(32'({oe, rs, w[1:0]}), 32'hD);
        end
        $display("test first bus done");

        xfer(2, 32'h1400_0010, 1'b1, 32'h0BAD_F00D);
        xfer(2, 32'h0000_0010, 1'b0, 32'h0);
        chk(rd, 32'h0BAD_F00D);
        xfer(2, 32'h0400_0000, 1'b0, 32'h0);
        chk(32'(oe), 32'h0);
        xfer(2, 32'h2000_0000, 1'b1, 32'h1);
        chk(32'(oe), 32'h0);
        xfer(0, 32'(REG_ERRCNT), 1'b0, 32'h0);
        chk(rd, 32'h3);
        chk(32'({rs, w[0]}), 32'h0);
        xfer(0, 32'(REG_ERRCNT), 1'b1, 32'h0);
        xfer(0, 32'(REG_ERRCNT), 1'b0, 32'h0);
        chk(rd, 32'h0);
        // unmapped offset reads zero
        xfer(0, 32'h0000_000C, 1'b0, 32'h0);
        chk(rd, 32'h0);
        // ssram off the second bus: its default slave answers the map
        xfer(0, 32'(REG_CTRL), 1'b1, 32'h0);
        xfer(2, 32'h1400_0010, 1'b0, 32'h0);
        chk(32'({oe, rs, w[1:0]}), 32'hD);
        chk(32'(sBridgeSelect), 32'h0);
        $display("test second bus done");

        xfer(0, 32'(REG_CTRL), 1'b1, 32'h7);
        while (tileMasterGrant[0] !== 1'b1)
            @(posedge ref_clk);
        chk(32'(pciMasterGrant), 32'h0);
        @(posedge ref_clk);
        chk(32'(sBusOe), 32'h1);
        chk(sBusOut.addr, 32'hABCD_0000);
        tileMaster[0].busReq <= 1'b0;
        pciStart <= 1'b1;
        while (pciOwned !== 1'b1)
            @(posedge ref_clk);
        chk(32'({pciMasterGrant, tileMasterGrant}), 32'h4);
        $display("test arbiter done");
        end_sim();
    end
endmodule : tg_bus_glue_tb

/* tb/tg_pci_master_model.sv */
// behavioural PCI master that competes for the slave-side bus
`timescale 1ns/100ps
module tg_pci_master_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // control from the bench
    input wire logic start,
    input wire logic [3:0] holdOff,
    // arbitration pins
    input wire logic pciMasterGrant,
    output logic pciMasterRequest,
    output logic pciMasterLockRequest,
    output logic owned
);
    import tg_pkg::*;
    logic [3:0] waitCnt;
    // ----------------------------------------
    // request after a hold-off, use the bus only once granted
    // ----------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || !start)
        begin
            pciMasterRequest <= 1'b0;
            owned <= 1'b0;
            waitCnt <= holdOff;
        end
        else if (waitCnt != 4'h0)
            waitCnt <= waitCnt - 4'h1;
        else
        begin
            pciMasterRequest <= 1'b1;
            owned <= pciMasterRequest && pciMasterGrant;
        end
    end
    // locked sequences are never issued by this model
    assign pciMasterLockRequest = 1'b0;
endmodule : tg_pci_master_model
